// ===== logic/dio_wdt.sv
`timescale 1ns/1ns
module dio_wdt #(
  parameter int LINES = 16
) (
  // Clock, reset, enable
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              clk_en,
  // Register port, 32-bit word accesses only
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  input  wire logic [7:0]        reg_addr,
  input  wire logic [31:0]       reg_wdata,
  output logic      [31:0]       reg_rdata,
  output logic                   reg_rvalid,
  // Watchdog tick at ADC base clock rate
  input  wire logic              wdt_tick,
  // Field lines
  input  wire logic [LINES-1:0]  line_in,
  output logic      [LINES-1:0]  line_out,
  output logic      [LINES-1:0]  line_oe,
  // Events to DAC and ADC sequencer, interrupt request and board reset
  output logic                   dac_load_event,
  output logic                   conv_start_event,
  output logic                   conv_trigger_event,
  output logic                   irq_req,
  output logic                   board_reset
);
  logic [LINES-1:0] sync1_reg, sync2_reg, sync3_reg, stable_reg;
  logic [31:0]      data_reg, dir_func_reg, wdt_ticks_reg, wdt_count_reg, irq_reg;
  logic             wdt_hold_reg;
  logic [31:0]      rdata_next;
  logic [LINES-1:0] oe_next, out_next, rise_w, fall_w, dir_w;
  logic [3:0]       edge_hit;
  logic [3:0]       irq_src_w;
  logic             wr_data, wr_dir, wr_wdt, wr_irq, wdt_fire, soft_rst;

  assign wr_data = reg_wr && reg_addr == dio_wdt_pkg::PIN_LEVELS_OFS;
  assign wr_dir  = reg_wr && reg_addr == dio_wdt_pkg::PIN_DIR_FUNC_OFS;
  assign wr_wdt  = reg_wr && reg_addr == dio_wdt_pkg::WDT_TICKS_OFS;
  assign wr_irq  = reg_wr && reg_addr == dio_wdt_pkg::IRQ_STATUS_OFS;

  // Direction per line: group 0 then one bit per line
  genvar g;
  generate
    for (g = 0; g < LINES; g++) begin : g_line
      if (g < 8) begin : g_low
        assign dir_w[g] = dir_func_reg[dio_wdt_pkg::DIR_GROUP0_BIT];
      end else begin : g_high
        assign dir_w[g] = dir_func_reg[g];
      end
      assign rise_w[g] = ~stable_reg[g] & sync2_reg[g] & sync3_reg[g];
      assign fall_w[g] = stable_reg[g] & ~sync2_reg[g] & ~sync3_reg[g];
    end
  endgenerate

  // Selected edge per secondary function
  function automatic logic pick(input logic en, input logic rising, input logic r, input logic f);
    pick = en & (rising ? r : f);
  endfunction

  assign edge_hit[0] = pick(dir_func_reg[dio_wdt_pkg::TRIG_EN_BIT], dir_func_reg[dio_wdt_pkg::TRIG_EN_BIT+1],
                            rise_w[dio_wdt_pkg::TRIG_LINE], fall_w[dio_wdt_pkg::TRIG_LINE]);
  assign edge_hit[1] = pick(dir_func_reg[dio_wdt_pkg::START_EN_BIT], dir_func_reg[dio_wdt_pkg::START_EN_BIT+1],
                            rise_w[dio_wdt_pkg::START_LINE], fall_w[dio_wdt_pkg::START_LINE]);
  assign edge_hit[2] = pick(dir_func_reg[dio_wdt_pkg::LOAD_EN_BIT], dir_func_reg[dio_wdt_pkg::LOAD_EN_BIT+1],
                            rise_w[dio_wdt_pkg::LOAD_LINE], fall_w[dio_wdt_pkg::LOAD_LINE]);
  assign edge_hit[3] = pick(dir_func_reg[dio_wdt_pkg::EXT_EN_BIT], dir_func_reg[dio_wdt_pkg::EXT_EN_BIT+1],
                            rise_w[dio_wdt_pkg::EXT_LINE], fall_w[dio_wdt_pkg::EXT_LINE]);

  // Latched sources gated by their enables
  assign irq_src_w[0] = irq_reg[dio_wdt_pkg::TRIG_STS_BIT] & irq_reg[dio_wdt_pkg::TRIG_IEN_BIT];
  assign irq_src_w[1] = irq_reg[dio_wdt_pkg::START_STS_BIT] & irq_reg[dio_wdt_pkg::START_IEN_BIT];
  assign irq_src_w[2] = irq_reg[dio_wdt_pkg::LOAD_STS_BIT] & irq_reg[dio_wdt_pkg::LOAD_IEN_BIT];
  assign irq_src_w[3] = irq_reg[dio_wdt_pkg::EXT_STS_BIT] & irq_reg[dio_wdt_pkg::EXT_IEN_BIT];

  // Watchdog expiry: armed only by a nonzero count
  assign wdt_fire = wdt_ticks_reg != 32'h0000_0000 && wdt_tick && wdt_count_reg == 32'h0000_0001 && !wr_wdt;
  assign soft_rst = !rst_n || wdt_fire;

  // Pin drive; watchdog line forced out, low after an expiry
  always_comb begin
    oe_next  = dir_w;
    out_next = data_reg[LINES-1:0] & dir_w;
    if (dir_func_reg[dio_wdt_pkg::WDT_PIN_EN_BIT]) begin
      oe_next[dio_wdt_pkg::WDT_LINE]  = 1'b1;
      out_next[dio_wdt_pkg::WDT_LINE] = ~irq_reg[dio_wdt_pkg::WDG_FLAG_BIT];
    end
    if (wdt_hold_reg) begin
      oe_next[dio_wdt_pkg::WDT_LINE]  = 1'b1;
      out_next[dio_wdt_pkg::WDT_LINE] = 1'b0;
    end
  end

  // Read data mux
  always_comb begin
    rdata_next = 32'h0000_0000;
    case (reg_addr)
      dio_wdt_pkg::PIN_LEVELS_OFS:
        rdata_next[LINES-1:0] = (stable_reg & ~dir_w) | (data_reg[LINES-1:0] & dir_w);
      dio_wdt_pkg::PIN_DIR_FUNC_OFS: rdata_next = dir_func_reg;
      dio_wdt_pkg::WDT_TICKS_OFS:    rdata_next = wdt_ticks_reg;
      dio_wdt_pkg::IRQ_STATUS_OFS:   rdata_next = irq_reg;
      default:                       rdata_next = 32'h0000_0000;
    endcase
  end

  // Three-stage pin synchroniser
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
      sync3_reg <= '0;
    end else if (clk_en) begin
      sync1_reg <= line_in;
      sync2_reg <= sync1_reg;
      sync3_reg <= sync2_reg;
    end
  end

  // Change accepted when stages two and three agree
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      stable_reg <= '0;
    end else if (clk_en) begin
      for (int i = 0; i < LINES; i++) begin
        if (sync2_reg[i] == sync3_reg[i]) begin
          stable_reg[i] <= sync3_reg[i];
        end
      end
    end
  end

  // Pin data, cleared by reset or expiry
  always_ff @(posedge mclk) begin
    if (soft_rst && (clk_en || !rst_n)) begin
      data_reg <= dio_wdt_pkg::PIN_DATA_RESET;
    end else if (clk_en && wr_data) begin
      data_reg <= reg_wdata;
    end
  end

  // Direction and functions, cleared by reset or expiry
  always_ff @(posedge mclk) begin
    if (soft_rst && (clk_en || !rst_n)) begin
      dir_func_reg <= dio_wdt_pkg::DIR_FUNC_RESET;
    end else if (clk_en && wr_dir) begin
      dir_func_reg <= reg_wdata & dio_wdt_pkg::DIR_FUNC_MASK;
    end
  end

  // Watchdog timeout, cleared by reset or expiry
  always_ff @(posedge mclk) begin
    if (soft_rst && (clk_en || !rst_n)) begin
      wdt_ticks_reg <= dio_wdt_pkg::WDT_TICKS_RESET;
    end else if (clk_en && wr_wdt) begin
      wdt_ticks_reg <= reg_wdata;
    end
  end

  // Tick counter
  always_ff @(posedge mclk) begin
    if (soft_rst && (clk_en || !rst_n)) begin
      wdt_count_reg <= dio_wdt_pkg::WDT_TICKS_RESET;
    end else if (clk_en) begin
      if (wr_wdt) begin
        wdt_count_reg <= reg_wdata;
      end else if (wdt_tick && wdt_count_reg != 32'h0000_0000) begin
        wdt_count_reg <= wdt_count_reg - 32'h0000_0001;
      end
    end
  end

  // Watchdog line hold: survives the expiry reset, dropped on hard reset or reconfigure
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      wdt_hold_reg <= 1'b0;
    end else if (clk_en) begin
      if (wdt_fire) begin
        wdt_hold_reg <= dir_func_reg[dio_wdt_pkg::WDT_PIN_EN_BIT];
      end else if (wr_dir) begin
        wdt_hold_reg <= 1'b0;
      end
    end
  end

  // Status flags: set beats clear; expired flag not cleared by expiry reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_reg <= dio_wdt_pkg::IRQ_RESET;
    end else if (clk_en) begin
      if (wdt_fire) begin
        irq_reg <= 32'h0000_0000;
        irq_reg[dio_wdt_pkg::WDG_FLAG_BIT] <= 1'b1;
      end else begin
        if (wr_irq) begin
          irq_reg[31:16] <= irq_reg[31:16] & ~reg_wdata[31:16];
          irq_reg[7:0]   <= reg_wdata[7:0] & dio_wdt_pkg::IRQ_WRITE_MASK[7:0];
        end
        if (edge_hit[0]) irq_reg[dio_wdt_pkg::TRIG_STS_BIT] <= 1'b1;
        if (edge_hit[1]) irq_reg[dio_wdt_pkg::START_STS_BIT] <= 1'b1;
        if (edge_hit[2]) irq_reg[dio_wdt_pkg::LOAD_STS_BIT] <= 1'b1;
        if (edge_hit[3]) irq_reg[dio_wdt_pkg::EXT_STS_BIT] <= 1'b1;
      end
    end
  end

  // Line drive outputs
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      line_out <= '0;
      line_oe  <= '0;
    end else if (clk_en) begin
      line_out <= out_next;
      line_oe  <= oe_next;
    end
  end

  // Read answer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reg_rdata  <= 32'h0000_0000;
      reg_rvalid <= 1'b0;
    end else if (clk_en) begin
      reg_rdata  <= rdata_next;
      reg_rvalid <= reg_rd;
    end
  end

  // Event pulses to DAC and ADC sequencer
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dac_load_event     <= 1'b0;
      conv_start_event   <= 1'b0;
      conv_trigger_event <= 1'b0;
    end else if (clk_en) begin
      dac_load_event     <= edge_hit[2];
      conv_start_event   <= edge_hit[1];
      conv_trigger_event <= edge_hit[0];
    end
  end

  // Interrupt request and board reset
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      irq_req     <= 1'b0;
      board_reset <= 1'b0;
    end else if (clk_en) begin
      irq_req     <= |irq_src_w;
      board_reset <= wdt_fire;
    end
  end
endmodule

// ===== logic/dio_wdt_pkg.sv
package dio_wdt_pkg;
  localparam logic [7:0]  PIN_LEVELS_OFS   = 8'h44;
  localparam logic [7:0]  PIN_DIR_FUNC_OFS = 8'h48;
  localparam logic [7:0]  WDT_TICKS_OFS    = 8'h4C;
  localparam logic [7:0]  IRQ_STATUS_OFS   = 8'h40;
  localparam int          DIR_GROUP0_BIT   = 0;
  localparam int          TRIG_EN_BIT      = 16;
  localparam int          START_EN_BIT     = 18;
  localparam int          LOAD_EN_BIT      = 20;
  localparam int          EXT_EN_BIT       = 22;
  localparam int          WDT_PIN_EN_BIT   = 24;
  localparam int          WDG_FLAG_BIT     = 31;
  localparam int          EXT_STS_BIT      = 23;
  localparam int          LOAD_STS_BIT     = 22;
  localparam int          START_STS_BIT    = 17;
  localparam int          TRIG_STS_BIT     = 16;
  localparam int          EXT_IEN_BIT      = 7;
  localparam int          LOAD_IEN_BIT     = 6;
  localparam int          START_IEN_BIT    = 1;
  localparam int          TRIG_IEN_BIT     = 0;
  localparam int          WDT_LINE         = 11;
  localparam int          LOAD_LINE        = 12;
  localparam int          EXT_LINE         = 13;
  localparam int          START_LINE       = 14;
  localparam int          TRIG_LINE        = 15;
  localparam logic [31:0] DIR_FUNC_RESET   = 32'h0000_0000;
  localparam logic [31:0] WDT_TICKS_RESET  = 32'h0000_0000;
  localparam logic [31:0] PIN_DATA_RESET   = 32'h0000_0000;
  localparam logic [31:0] IRQ_RESET        = 32'h0000_0000;
  localparam logic [31:0] DIR_FUNC_MASK    = 32'h01FF_FF01;
  localparam logic [31:0] IRQ_WRITE_MASK   = 32'h0000_00FF;
endpackage

// ===== test/digital_io_with_watchdog_tb_top.sv
`timescale 1ns/1ns
module digital_io_with_watchdog_tb_top;
  logic        mclk = 0, rst_n = 0, reg_wr = 0, reg_rd = 0, wdt_tick = 0, clk_en = 1;
  logic [7:0]  reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0, q, d, v, s = 32'h00010AD9;
  logic [15:0] fdrv = 16'h0000, line_in, line_out, line_oe, x;
  logic [31:0] reg_rdata;
  logic        reg_rvalid, dac_load_event, conv_start_event, conv_trigger_event, irq_req, board_reset;
  int          failures = 0, total_checks = 0, evc = 0, exp_ev = 0, barks = 0;
  int          ln[4] = '{12, 13, 14, 15}, en[4] = '{20, 22, 18, 16}, st[4] = '{22, 23, 17, 16};
  dio_wdt dio_wdt_i (.mclk(mclk), .rst_n(rst_n), .clk_en(clk_en), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
    .wdt_tick(wdt_tick), .line_in(line_in), .line_out(line_out), .line_oe(line_oe),
    .dac_load_event(dac_load_event), .conv_start_event(conv_start_event),
    .conv_trigger_event(conv_trigger_event), .irq_req(irq_req), .board_reset(board_reset));
  field_model field_model_i (.line_out(line_out), .line_oe(line_oe), .drive(fdrv), .line_in(line_in));
  initial forever #20 mclk = ~mclk;
  always @(posedge mclk) begin
    evc   <= evc + int'(dac_load_event) + int'(conv_start_event) + int'(conv_trigger_event);
    barks <= barks + int'(board_reset);
  end
  function logic [31:0] nxt(input logic [31:0] a);
    return {a[30:0], a[31] ^ a[21] ^ a[1] ^ a[0]};
  endfunction
  function logic [15:0] oe_of(input logic [31:0] c);
    return {c[15:8], {8{c[0]}}};
  endfunction
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      failures++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task wr(input logic [7:0] a, input logic [31:0] w);
    @(posedge mclk) begin reg_wr <= 1; reg_addr <= a; reg_wdata <= w; end
    @(posedge mclk) reg_wr <= 0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge mclk) begin reg_rd <= 1; reg_addr <= a; end
    @(posedge mclk) reg_rd <= 0;
    #1 q = reg_rdata;
    chk(32'(reg_rvalid), 32'h1);
  endtask
  task tick(input int n);
    repeat (n) begin @(posedge mclk) wdt_tick <= 1; @(posedge mclk) wdt_tick <= 0; end
  endtask
  task end_sim;
    $display("checks=%0d failures=%0d", total_checks, failures);
    if (failures == 0 && total_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  initial begin
    #2000000 failures++;
    end_sim();
  end
  initial begin
    repeat (8) @(posedge mclk);
    rst_n <= 1;
    rd(8'h48); chk(q, 32'h0);
    rd(8'h4C); chk(q, 32'h0);
    rd(8'h60); chk(q, 32'h0);
    chk(32'(line_oe), 32'h0);
    $display("test reset done");
    for (int i = 0; i < 5; i++) begin
      s = nxt(s); d = (i == 0) ? 32'h0000FF01 : (i == 1) ? 32'h0 : s & 32'h0000FF01;
      s = nxt(s); v = s; s = nxt(s); fdrv <= s[15:0];
      wr(8'h48, d); wr(8'h44, v); repeat (4) @(posedge mclk); rd(8'h44); x = oe_of(d);
      chk(32'(q[15:0]), 32'((v[15:0] & x) | (fdrv & ~x)));
      chk(32'(line_oe), 32'(x));
      chk(32'(line_out), 32'(v[15:0] & x));
      rd(8'h48); chk(q, d);
    end
    $display("test lines done");
    wr(8'h44, 32'h0); wr(8'h48, 32'h0); fdrv <= 16'h0000;
    for (int f = 0; f < 8; f++) begin
      fdrv[ln[f%4]] <= !(f / 4); repeat (8) @(posedge mclk);
      wr(8'h48, (32'h1 << en[f%4]) | (32'(f / 4) << (en[f%4] + 1)));
      wr(8'h40, (f / 4) ? 32'h000000C3 : 32'h0);
      fdrv[ln[f%4]] <= f / 4; repeat (8) @(posedge mclk);
      fdrv[ln[f%4]] <= !(f / 4); repeat (8) @(posedge mclk);
      exp_ev += int'(f % 4 != 1);
      #1 chk(32'(evc), 32'(exp_ev));
      chk(32'(irq_req), 32'(f / 4));
      rd(8'h40); chk(q, (32'h1 << st[f%4]) | ((f / 4) ? 32'hC3 : 32'h0));
      wr(8'h40, 32'hFFFFFF00); rd(8'h40); chk(q, 32'h0);
    end
    $display("test functions done");
    wr(8'h48, 32'h01000000); rd(8'h44);
    chk(32'(line_oe[11]), 32'h1);
    chk(32'(line_out[11]), 32'h1);
    wr(8'h4C, 32'h5); tick(3); wr(8'h4C, 32'h5); tick(4);
    #1 chk(32'(barks), 32'h0);
    tick(1); repeat (3) @(posedge mclk);
    #1 chk(32'(barks), 32'h1);
    chk(32'(line_oe[11]), 32'h1);
    chk(32'(line_out[11]), 32'h0);
    rd(8'h40); chk(q, 32'h80000000);
    rd(8'h48); chk(q, 32'h0);
    wr(8'h40, 32'h80000000); rd(8'h40); chk(q, 32'h0);
    wr(8'h4C, 32'h0); tick(20);
    #1 chk(32'(barks), 32'h1);
    $display("test watchdog done");
    clk_en <= 0; wr(8'h4C, 32'h7); clk_en <= 1;
    rd(8'h4C); chk(q, 32'h0);
    $display("test freeze done");
    end_sim();
  end
endmodule
bind dio_wdt dio_wdt_assertions dio_wdt_assertions_i (.mclk(mclk), .rst_n(rst_n), .reg_wr(reg_wr),
  .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rvalid(reg_rvalid), .line_in(line_in),
  .line_out(line_out), .line_oe(line_oe), .dac_load_event(dac_load_event), .conv_start_event(conv_start_event),
  .conv_trigger_event(conv_trigger_event), .board_reset(board_reset));

// ===== test/dio_wdt_assertions.sv
`timescale 1ns/1ns
module dio_wdt_assertions (
  input wire logic        mclk,
  input wire logic        rst_n,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [7:0]  reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_rvalid,
  input wire logic [15:0] line_in,
  input wire logic [15:0] line_out,
  input wire logic [15:0] line_oe,
  input wire logic        dac_load_event,
  input wire logic        conv_start_event,
  input wire logic        conv_trigger_event,
  input wire logic        board_reset
);
  logic [31:0] cfg_reg;
  logic        off_reg;
  wire         cfg_wr = reg_wr && reg_addr == 8'h48;
  wire         wdt_wr = reg_wr && reg_addr == 8'h4C;
  always_ff @(posedge mclk) begin
    cfg_reg <= (!rst_n || board_reset) ? 32'h0 : cfg_wr ? reg_wdata : cfg_reg;
    off_reg <= (!rst_n || board_reset) ? 1'b1 : wdt_wr ? reg_wdata == 32'h0 : off_reg;
  end
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  AST_RVALID: assert property (reg_rd |=> reg_rvalid) else $error("read without answer");
  AST_DIR: assert property (cfg_wr |-> ##2 line_oe[7:0] == {8{$past(reg_wdata[0], 2)}})
    else $error("group 0 direction wrong");
  AST_PIN: assert property (cfg_reg[24] && $past(cfg_reg[24]) |-> line_oe[11])
    else $error("status line not driven");
  AST_LOW: assert property (board_reset && cfg_reg[24] |-> ##[0:2] (line_oe[11] && !line_out[11]))
    else $error("status line not low after expiry");
  AST_LOAD: assert property (dac_load_event |-> cfg_reg[20] && line_in[12] == cfg_reg[21])
    else $error("bad load event");
  AST_START: assert property (conv_start_event |-> cfg_reg[18] && line_in[14] == cfg_reg[19])
    else $error("bad start event");
  AST_TRIG: assert property (conv_trigger_event |-> cfg_reg[16] && line_in[15] == cfg_reg[17])
    else $error("bad trigger event");
  AST_ZERO: assert property (off_reg && $past(off_reg) |-> !board_reset)
    else $error("reset while disabled");
  cover property (dac_load_event);
  cover property (conv_start_event);
  cover property (board_reset);
endmodule

// ===== test/field_model.sv
`timescale 1ns/1ns
module field_model (
  input  wire logic [15:0] line_out,
  input  wire logic [15:0] line_oe,
  input  wire logic [15:0] drive,
  output logic      [15:0] line_in
);
  // Driven lines follow the card, others the field
  assign line_in = (line_out & line_oe) | (drive & ~line_oe);
endmodule
